// [rtl/csl_consts.vh]
// Constants for the status and link special register block
// Operation
// - Non-IEEE mode set: a would-be denormal result becomes signed zero.
// - Round mode field: 00 nearest, 01 zero, 10 plus inf, 11 minus inf.
// - Five class flags C,<,>,=,? encode each result value class.
// - Exception flags reflect the whole instruction result, not partial sums.
// - Summary overflow sticky on overflow set; cleared by special write or copy.
// - Summary overflow untouched by compares and non-overflowing instructions.
// - Special write with summary 0 and overflow 1 leaves summary clear, overflow set.
// - Add/subtract/negate with overflow enable: overflow = carry in xor carry out.
// - Multiply low/divide with overflow enable: overflow when result exceeds 32 bits.
// - Compares leave overflow unchanged; special write and copy excepted.
// - Carrying and extended add/subtract set carry on carry out, else clear.
// - Shift right algebraic: carry when negative operand lost one-bits.
// - Carry unchanged by instructions not producing carry, with listed exceptions.
// - Exception register is 32 bits, flags in top three bits.
// - Seven-bit byte count in low bits feeds indexed string moves.
// - Link register supplies the branch target for branch-to-link.
// - Link low two bits stored but ignored as branch address.
// - Branch with link option loads address of the next instruction.
// - Link register read and written via special register number 8.
// - Exception register selected by special register number 1.
`ifndef CSL_CONSTS_VH
`define CSL_CONSTS_VH
`define CSL_SPR_XER_NUM 10'h001
`define CSL_SPR_LINK_NUM 10'h008
// Big-endian bit numbers mapped to little-endian positions
`define CSL_XER_SO_POS 31
`define CSL_XER_OV_POS 30
`define CSL_XER_CA_POS 29
`define CSL_XER_BC_MSB 6
`define CSL_XER_RESET 32'h0000_0000
`define CSL_LINK_RESET 32'h0000_0000
`define CSL_FP_NI_POS 2
`define CSL_FP_RN_MSB 1
`define CSL_FP_RESET 3'h0
// Rounding mode codes
`define CSL_RN_NEAREST 2'h0
`define CSL_RN_ZERO 2'h1
`define CSL_RN_POS_INF 2'h2
`define CSL_RN_NEG_INF 2'h3
// Result class codes, order C < > = ?
`define CSL_FPRF_QNAN 5'h11
`define CSL_FPRF_NEG_INF 5'h09
`define CSL_FPRF_NEG_NORM 5'h08
`define CSL_FPRF_NEG_DEN 5'h18
`define CSL_FPRF_NEG_ZERO 5'h12
`define CSL_FPRF_POS_ZERO 5'h02
`define CSL_FPRF_POS_DEN 5'h14
`define CSL_FPRF_POS_NORM 5'h04
`define CSL_FPRF_POS_INF 5'h05
// Fixed-point operation classes
`define CSL_OP_NONE 4'h0
`define CSL_OP_ADD 4'h1
`define CSL_OP_ADD_CARRY 4'h2
`define CSL_OP_MUL_DIV 4'h3
`define CSL_OP_SHIFT_ALG 4'h4
`define CSL_OP_COMPARE 4'h5
`define CSL_OP_COPY_XER 4'h6
`endif

// [rtl/csl_fp_class.v]
// Floating-point result classifier with non-IEEE flush
`timescale 1ns/10ps
`include "csl_consts.vh"
module csl_fp_class (
   // Raw result classification
   input wire sign_in,
   input wire is_nan_in,
   input wire is_inf_in,
   input wire is_zero_in,
   input wire is_denorm_in,
   // Mode
   input wire nonieee_mode_in,
   // Results
   output reg flush_to_zero_out,
   output reg [4:0] class_flags_out
);
   // Denormals collapse to signed zero under non-IEEE mode
   always @* begin
      flush_to_zero_out = nonieee_mode_in & is_denorm_in & ~is_nan_in & ~is_inf_in;
      if (is_nan_in) begin
         class_flags_out = `CSL_FPRF_QNAN;
      end else if (is_inf_in) begin
         class_flags_out = sign_in ? `CSL_FPRF_NEG_INF : `CSL_FPRF_POS_INF;
      end else if (is_zero_in | flush_to_zero_out) begin
         class_flags_out = sign_in ? `CSL_FPRF_NEG_ZERO : `CSL_FPRF_POS_ZERO;
      end else if (is_denorm_in) begin
         class_flags_out = sign_in ? `CSL_FPRF_NEG_DEN : `CSL_FPRF_POS_DEN;
      end else begin
         class_flags_out = sign_in ? `CSL_FPRF_NEG_NORM : `CSL_FPRF_POS_NORM;
      end
   end
endmodule // csl_fp_class

// [rtl/csl_status_link.v]
// Exception status, link and rounding-control register block
`timescale 1ns/10ps
`include "csl_consts.vh"
module csl_status_link #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Special register move port
   input wire spr_write_in,
   input wire [9:0] special_reg_number_in,
   input wire [31:0] spr_wdata_in,
   output reg [31:0] spr_rdata_out,
   output reg spr_hit_out,
   // Floating-point control writes
   input wire fp_ctrl_write_in,
   input wire nonieee_mode_wr_in,
   input wire [1:0] round_mode_wr_in,
   // Fixed-point completion (whole-instruction results)
   input wire op_valid_in,
   input wire [3:0] op_class_in,
   input wire overflow_enable_in,
   input wire [31:0] op_a_in,
   input wire [31:0] op_b_in,
   input wire carry_in_in,
   input wire sub_in,
   input wire shift_neg_in,
   input wire shift_lost_ones_in,
   input wire muldiv_overflow_in,
   // Branch with link update
   input wire branch_link_in,
   input wire [31:0] branch_pc_in,
   // Floating-point result classification
   input wire fp_valid_in,
   input wire fp_sign_in,
   input wire fp_is_nan_in,
   input wire fp_is_inf_in,
   input wire fp_is_zero_in,
   input wire fp_is_denorm_in,
   // Outputs
   output reg [31:0] link_target_out,
   output reg [6:0] string_byte_count_out,
   output reg nonieee_mode_out,
   output reg [1:0] round_mode_field_out,
   output reg [4:0] class_flags_out,
   output reg flush_to_zero_out,
   output reg [3:0] copied_flags_out,
   output reg copy_valid_out
);
   // Full-width add producing carry into and out of msb
   function [1:0] csl_carries;
      input [31:0] a;
      input [31:0] b;
      input cin;
      reg [32:0] sum;
      reg [31:0] low;
      begin
         sum = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
         low = {1'b0, a[30:0]} + {1'b0, b[30:0]} + {31'h0000_0000, cin};
         csl_carries = {sum[32], low[31]};
      end
   endfunction

   // ************************************************
   // State
   // ************************************************
   reg so_reg;
   reg so_next;
   reg ov_reg;
   reg ov_next;
   reg ca_reg;
   reg ca_next;
   reg [6:0] bc_reg;
   reg [6:0] bc_next;
   reg [31:0] link_reg;
   reg [31:0] link_next;
   reg ni_reg;
   reg [1:0] rn_reg;
   wire [1:0] carries;
   wire [31:0] b_eff;
   wire [31:0] xer_value;
   wire cls_flush;
   wire [4:0] cls_flags;
   wire xer_sel;
   wire link_sel;

   assign xer_sel = spr_write_in & (special_reg_number_in == `CSL_SPR_XER_NUM);
   assign link_sel = spr_write_in & (special_reg_number_in == `CSL_SPR_LINK_NUM);
   // Subtract-from is complement plus carry, computed once over the whole operation
   assign b_eff = sub_in ? ~op_b_in : op_b_in;
   assign carries = csl_carries(op_a_in, b_eff, carry_in_in);
   // Reserved bits forced to zero on read
   assign xer_value = {so_reg, ov_reg, ca_reg, 22'h00_0000, bc_reg};

   // ************************************************
   // Exception flag update
   // ************************************************
   // Special write wins over a same-cycle instruction: both claim the register
   always @* begin
      so_next = so_reg;
      ov_next = ov_reg;
      ca_next = ca_reg;
      bc_next = bc_reg;
      if (xer_sel) begin
         so_next = spr_wdata_in[`CSL_XER_SO_POS];
         ov_next = spr_wdata_in[`CSL_XER_OV_POS];
         ca_next = spr_wdata_in[`CSL_XER_CA_POS];
         bc_next = spr_wdata_in[`CSL_XER_BC_MSB:0];
      end else if (op_valid_in) begin
         case (op_class_in)
            `CSL_OP_ADD: begin
               if (overflow_enable_in) begin
                  ov_next = carries[1] ^ carries[0];
                  so_next = so_reg | ov_next;
               end
            end
            `CSL_OP_ADD_CARRY: begin
               ca_next = carries[1];
               if (overflow_enable_in) begin
                  ov_next = carries[1] ^ carries[0];
                  so_next = so_reg | ov_next;
               end
            end
            `CSL_OP_MUL_DIV: begin
               if (overflow_enable_in) begin
                  ov_next = muldiv_overflow_in;
                  so_next = so_reg | ov_next;
               end
            end
            `CSL_OP_SHIFT_ALG: begin
               ca_next = shift_neg_in & shift_lost_ones_in;
            end
            `CSL_OP_COPY_XER: begin
               so_next = 1'b0;
               ov_next = 1'b0;
               ca_next = 1'b0;
            end
            `CSL_OP_COMPARE: begin
               so_next = so_reg;
            end
            default: begin
               so_next = so_reg;
            end
         endcase
      end
   end

   // ************************************************
   // Link register update
   // ************************************************
   // Register write and branch link in one cycle: the software write wins
   always @* begin
      link_next = link_reg;
      if (link_sel) begin
         link_next = spr_wdata_in;
      end else if (branch_link_in) begin
         link_next = branch_pc_in + 32'h0000_0004;
      end
   end

   // Registers
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         so_reg <= 1'b0;
         ov_reg <= 1'b0;
         ca_reg <= 1'b0;
         bc_reg <= 7'h00;
         link_reg <= `CSL_LINK_RESET;
         ni_reg <= 1'b0;
         rn_reg <= `CSL_RN_NEAREST;
      end else begin
         so_reg <= so_next;
         ov_reg <= ov_next;
         ca_reg <= ca_next;
         bc_reg <= bc_next;
         link_reg <= link_next;
         if (fp_ctrl_write_in) begin
            ni_reg <= nonieee_mode_wr_in;
            rn_reg <= round_mode_wr_in;
         end
      end
   end

   // Classifier for floating-point results
   csl_fp_class u_class (
      .sign_in(fp_sign_in),
      .is_nan_in(fp_is_nan_in),
      .is_inf_in(fp_is_inf_in),
      .is_zero_in(fp_is_zero_in),
      .is_denorm_in(fp_is_denorm_in),
      .nonieee_mode_in(ni_reg),
      .flush_to_zero_out(cls_flush),
      .class_flags_out(cls_flags)
   );

   // ************************************************
   // Registered outputs
   // ************************************************
   // Read data one cycle after the move-from request
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         spr_rdata_out <= 32'h0000_0000;
         spr_hit_out <= 1'b0;
         link_target_out <= 32'h0000_0000;
         string_byte_count_out <= 7'h00;
         nonieee_mode_out <= 1'b0;
         round_mode_field_out <= `CSL_RN_NEAREST;
         class_flags_out <= 5'h00;
         flush_to_zero_out <= 1'b0;
         copied_flags_out <= 4'h0;
         copy_valid_out <= 1'b0;
      end else begin
         if (special_reg_number_in == `CSL_SPR_XER_NUM) begin
            spr_rdata_out <= xer_value;
            spr_hit_out <= 1'b1;
         end else if (special_reg_number_in == `CSL_SPR_LINK_NUM) begin
            spr_rdata_out <= link_reg;
            spr_hit_out <= 1'b1;
         end else begin
            spr_rdata_out <= 32'h0000_0000;
            spr_hit_out <= 1'b0;
         end
         // Low two bits masked off for fetch
         link_target_out <= {link_next[31:2], 2'b00};
         string_byte_count_out <= bc_next;
         nonieee_mode_out <= ni_reg;
         round_mode_field_out <= rn_reg;
         if (fp_valid_in) begin
            class_flags_out <= cls_flags;
            flush_to_zero_out <= cls_flush;
         end
         // Old flags handed to the condition field before clearing
         copy_valid_out <= op_valid_in & ~xer_sel & (op_class_in == `CSL_OP_COPY_XER);
         if (op_valid_in & ~xer_sel & (op_class_in == `CSL_OP_COPY_XER)) begin
            copied_flags_out <= {so_reg, ov_reg, ca_reg, 1'b0};
         end
      end
   end
endmodule // csl_status_link

// [tb/csl_exec_model.sv]
// Execution pipeline model issuing fixed-point completions
`timescale 1ns/10ps
module csl_exec_model (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Request from the bench
   input wire go_in,
   input wire [3:0] cls_in,
   input wire oe_in,
   input wire [31:0] a_in,
   input wire [31:0] b_in,
   input wire [4:0] misc_in,
   // Completion towards the block
   output reg op_valid_out,
   output reg [3:0] op_class_out,
   output reg oe_out,
   output reg [31:0] a_out,
   output reg [31:0] b_out,
   output reg [4:0] misc_out
);
   // Whole result in one cycle; idle operands toggle so stale values never match
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         {op_valid_out, op_class_out, oe_out, a_out, b_out, misc_out} <= 75'h0;
      end else begin
         op_valid_out <= go_in;
         op_class_out <= cls_in;
         oe_out <= oe_in;
         a_out <= go_in ? a_in : ~a_out;
         b_out <= go_in ? b_in : ~b_out;
         misc_out <= misc_in;
      end
   end
endmodule // csl_exec_model

// [tb/csl_status_link_props.sv]
// Port checker for the status and link register block
`timescale 1ns/10ps
module csl_status_link_props (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Watched ports
   input wire spr_write_in,
   input wire [9:0] special_reg_number_in,
   input wire [31:0] spr_wdata_in,
   input wire [31:0] spr_rdata_out,
   input wire spr_hit_out,
   input wire fp_ctrl_write_in,
   input wire [1:0] round_mode_wr_in,
   input wire op_valid_in,
   input wire [3:0] op_class_in,
   input wire overflow_enable_in,
   input wire muldiv_overflow_in,
   input wire branch_link_in,
   input wire [31:0] branch_pc_in,
   input wire [31:0] link_target_out,
   input wire [6:0] string_byte_count_out,
   input wire [1:0] round_mode_field_out,
   input wire copy_valid_out
);
   // Select decodes; rdata lags the state by a cycle
   wire x1 = special_reg_number_in == 10'h001;
   wire xw = spr_write_in && x1;
   wire lw = spr_write_in && special_reg_number_in == 10'h008;
   wire cp = op_valid_in && op_class_in == 4'h6 && !xw;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_unmapped; !x1 && !lw && special_reg_number_in != 10'h008 |=> spr_rdata_out == 32'h0 && !spr_hit_out; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_hit; x1 |=> spr_hit_out && spr_rdata_out[28:7] == 22'h0; endproperty
   a_hit: assert property (p_hit) else $error("exception reg read bad");
   property p_branch; branch_link_in && !lw |=> link_target_out == (($past(branch_pc_in) + 32'h4) & 32'hFFFF_FFFC); endproperty
   a_branch: assert property (p_branch) else $error("branch link value wrong");
   property p_link_wr; lw |=> link_target_out == {$past(spr_wdata_in[31:2]), 2'h0}; endproperty
   a_link_wr: assert property (p_link_wr) else $error("link target wrong");
   property p_count; xw |=> string_byte_count_out == $past(spr_wdata_in[6:0]); endproperty
   a_count: assert property (p_count) else $error("byte count wrong");
   property p_round; fp_ctrl_write_in |-> ##2 round_mode_field_out == $past(round_mode_wr_in, 2); endproperty
   a_round: assert property (p_round) else $error("round mode wrong");
   property p_muldiv; op_valid_in && op_class_in == 4'h3 && overflow_enable_in && muldiv_overflow_in && !xw ##1 x1 |=> spr_rdata_out[31:30] == 2'h3; endproperty
   a_muldiv: assert property (p_muldiv) else $error("overflow not set");
   property p_copy; cp ##1 x1 |-> copy_valid_out ##1 spr_rdata_out[31:29] == 3'h0; endproperty
   a_copy: assert property (p_copy) else $error("copy did not clear");
   property p_sticky; (x1 && !xw && !cp) ##1 (x1 && spr_rdata_out[31]) |=> spr_rdata_out[31]; endproperty
   a_sticky: assert property (p_sticky) else $error("summary overflow lost");
   c_copy: cover property (copy_valid_out);
   c_branch: cover property (branch_link_in);
   c_ovf: cover property (op_valid_in && muldiv_overflow_in);
endmodule // csl_status_link_props
bind csl_status_link csl_status_link_props i_props (.sys_clk_in, .rst_in, .spr_write_in,
   .special_reg_number_in, .spr_wdata_in, .spr_rdata_out, .spr_hit_out, .fp_ctrl_write_in,
   .round_mode_wr_in, .op_valid_in, .op_class_in, .overflow_enable_in, .muldiv_overflow_in,
   .branch_link_in, .branch_pc_in, .link_target_out, .string_byte_count_out,
   .round_mode_field_out, .copy_valid_out);

// [tb/csl_status_link_tb.sv]
// Self-checking bench for the status and link register block
`timescale 1ns/10ps
module csl_status_link_tb;
   reg sys_clk_in = 1'b0, rst_in = 1'b1, spr_write_in = 1'b0, go = 1'b0, oe = 1'b0;
   reg fp_ctrl_write_in = 1'b0, nonieee_mode_wr_in = 1'b0, branch_link_in = 1'b0, fp_valid_in = 1'b0;
   reg [9:0] special_reg_number_in = 10'h001;
   reg [31:0] spr_wdata_in = 32'h0, a = 32'h0, b = 32'h0, branch_pc_in = 32'h0;
   reg [1:0] round_mode_wr_in = 2'h0;
   reg [3:0] cls = 4'h0;
   reg [4:0] misc = 5'h0, fp5 = 5'h0;
   wire ov, oen, fnm, ftz, cpv, hit;
   wire [3:0] oc, cpf;
   wire [31:0] oa, ob, rdata, lt;
   wire [4:0] om, cf;
   wire [6:0] bc;
   wire [1:0] rm;
   integer failures = 0, comparisons = 0, i;
   // Class table {sign,nan,inf,zero,den,flags}
   reg [89:0] tab = {10'h111, 10'h289, 10'h208, 10'h238, 10'h252, 10'h042, 10'h034, 10'h004, 10'h085};
   csl_exec_model i_model (.sys_clk_in, .rst_in, .go_in(go), .cls_in(cls), .oe_in(oe), .a_in(a),
      .b_in(b), .misc_in(misc), .op_valid_out(ov), .op_class_out(oc), .oe_out(oen), .a_out(oa),
      .b_out(ob), .misc_out(om));
   csl_status_link i_dut (.sys_clk_in, .rst_in, .spr_write_in, .special_reg_number_in,
      .spr_wdata_in, .spr_rdata_out(rdata), .spr_hit_out(hit), .fp_ctrl_write_in,
      .nonieee_mode_wr_in, .round_mode_wr_in, .op_valid_in(ov), .op_class_in(oc),
      .overflow_enable_in(oen), .op_a_in(oa), .op_b_in(ob), .carry_in_in(om[4]), .sub_in(om[3]),
      .shift_neg_in(om[2]), .shift_lost_ones_in(om[1]), .muldiv_overflow_in(om[0]),
      .branch_link_in, .branch_pc_in, .fp_valid_in, .fp_sign_in(fp5[4]), .fp_is_nan_in(fp5[3]),
      .fp_is_inf_in(fp5[2]), .fp_is_zero_in(fp5[1]), .fp_is_denorm_in(fp5[0]),
      .link_target_out(lt), .string_byte_count_out(bc), .nonieee_mode_out(fnm),
      .round_mode_field_out(rm), .class_flags_out(cf), .flush_to_zero_out(ftz),
      .copied_flags_out(cpf), .copy_valid_out(cpv));
   // Free-running 20 MHz clock
   initial begin
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   task chk(input string nm, input [31:0] e, input [31:0] s);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            failures = failures + 1;
            $display("FAIL %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // Read address held three edges so the lagging read data settles
   task rd(input [9:0] n, input [31:0] e);
      begin
         @(posedge sys_clk_in) special_reg_number_in <= n;
         repeat (3) @(posedge sys_clk_in);
         #1 chk("read data", e, rdata);
      end
   endtask
   task wr(input [9:0] n, input [31:0] d);
      begin
         @(posedge sys_clk_in) spr_write_in <= 1'b1;
         special_reg_number_in <= n;
         spr_wdata_in <= d;
         @(posedge sys_clk_in) spr_write_in <= 1'b0;
      end
   endtask
   // One completion, then the exception register is compared
   task op(input [3:0] c, input o, input [31:0] x, input [31:0] y, input [4:0] m, input [31:0] e);
      begin
         @(posedge sys_clk_in) go <= 1'b1;
         cls <= c;
         oe <= o;
         a <= x;
         b <= y;
         misc <= m;
         @(posedge sys_clk_in) go <= 1'b0;
         rd(10'h001, e);
      end
   endtask
   task fpc(input n, input [1:0] r);
      begin
         @(posedge sys_clk_in) fp_ctrl_write_in <= 1'b1;
         nonieee_mode_wr_in <= n;
         round_mode_wr_in <= r;
         @(posedge sys_clk_in) fp_ctrl_write_in <= 1'b0;
         repeat (2) @(posedge sys_clk_in);
         #1;
      end
   endtask
   task fp(input [4:0] v);
      begin
         @(posedge sys_clk_in) fp_valid_in <= 1'b1;
         fp5 <= v;
         @(posedge sys_clk_in) fp_valid_in <= 1'b0;
         @(posedge sys_clk_in) #1;
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(10'h001, 32'h0);
      rd(10'h002, 32'h0);
      wr(10'h001, 32'hFFFF_FFFF);
      rd(10'h001, 32'hE000_007F);
      chk("byte count", 32'h7F, bc);
      wr(10'h001, 32'h4000_0000);
      rd(10'h001, 32'h4000_0000);
      $display("test exception writes done");
      op(4'h1, 1'b1, 32'h7FFF_FFFF, 32'h1, 5'h00, 32'hC000_0000);
      op(4'h1, 1'b1, 32'h1, 32'h1, 5'h00, 32'h8000_0000);
      op(4'h5, 1'b0, 32'hFFFF_FFFF, 32'h1, 5'h00, 32'h8000_0000);
      op(4'h2, 1'b0, 32'hFFFF_FFFF, 32'h1, 5'h00, 32'hA000_0000);
      op(4'h2, 1'b0, 32'h0, 32'h0, 5'h00, 32'h8000_0000);
      op(4'h2, 1'b0, 32'h5, 32'h5, 5'h18, 32'hA000_0000);
      op(4'h4, 1'b0, 32'h0, 32'h0, 5'h04, 32'h8000_0000);
      op(4'h4, 1'b0, 32'h0, 32'h0, 5'h06, 32'hA000_0000);
      op(4'h6, 1'b0, 32'h0, 32'h0, 5'h00, 32'h0);
      chk("copied flags", 32'hA, cpf);
      op(4'h3, 1'b1, 32'h0, 32'h0, 5'h01, 32'hC000_0000);
      op(4'h3, 1'b1, 32'h0, 32'h0, 5'h00, 32'h8000_0000);
      $display("test flag updates done");
      wr(10'h008, 32'h1234_5677);
      rd(10'h008, 32'h1234_5677);
      chk("link target", 32'h1234_5674, lt);
      @(posedge sys_clk_in) branch_link_in <= 1'b1;
      branch_pc_in <= 32'h0000_0100;
      @(posedge sys_clk_in) branch_link_in <= 1'b0;
      rd(10'h008, 32'h0000_0104);
      $display("test link done");
      for (i = 0; i < 4; i = i + 1) begin
         fpc(1'b0, i[1:0]);
         chk("round mode", i, rm);
      end
      for (i = 0; i < 9; i = i + 1) begin
         fp(tab[i*10+5 +: 5]);
         chk("class flags", tab[i*10 +: 5], cf);
      end
      fpc(1'b1, 2'h0);
      chk("nonieee mode", 32'h1, fnm);
      fp(5'h11);
      chk("flush", 32'h1, ftz);
      chk("flushed class", 32'h12, cf);
      $display("test floating point done");
      print_verdict;
   end
   // Hang guard, well beyond the sequence length
   initial begin
      #200_000;
      failures = failures + 1;
      print_verdict;
   end
endmodule // csl_status_link_tb
